// ### bench/alarm_limit_annunciator_bench.sv
`timescale 1ns/10ps
// Self-checking bench: bus tasks, a sensor feed and panel stimulus.
module alarm_limit_annunciator_bench;
    import annunciator_pkg::*;
    logic          clk_i = 1'b0;
    logic          rst_i = 1'b1;
    logic [7:0]    adr = 8'h00;
    logic [31:0]   wdat = 32'h0, rq;
    logic          we = 1'b0, cyc = 1'b0, stb = 1'b0, swa = 1'b0, go = 1'b0;
    logic [3:0]    btn = 4'h0;
    logic [1:0]    mclr = 2'h0, mode_v = 2'h0;
    logic [6:0]    sch = 7'h00;
    logic [11:0]   sval = 12'h000, lv;
    wire  [31:0]   dat_o;
    wire           ack_o, tone_o, soft_o, irq_o, sv;
    wire  [3:0]    lamp_o;
    wire  [39:0]   ann_o;
    wire  [119:0]  st_o;
    wire  [11:0]   lv_o, sd;
    wire  [6:0]    sc;
    int            n_errors = 0, checks_done = 0, i;
    integer        seed = 52169;
    // The clock runs at 10 MHz.
    always #50 clk_i = ~clk_i;
    sensor_feed sensor_feed_i (.clk_i(clk_i), .go_i(go), .ch_i(sch), .val_i(sval),
        .smp_valid_o(sv), .smp_chan_o(sc), .smp_value_o(sd));
    alarm_annunciator alarm_annunciator_i (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr),
        .dat_i(wdat), .we_i(we), .sel_i(4'hF), .cyc_i(cyc), .stb_i(stb), .dat_o(dat_o),
        .ack_o(ack_o), .smp_valid_i(sv), .smp_chan_i(sc), .smp_value_i(sd),
        .alert_button_i(btn), .memory_clear_i(mclr), .software_alert_i(swa),
        .tone_o(tone_o), .software_tone_o(soft_o), .alert_lamp_o(lamp_o),
        .annunciator_o(ann_o), .status_lamp_o(st_o), .limit_volts_o(lv_o), .irq_o(irq_o));
    // Compare one value and count it.
    task chk(input logic [119:0] seen, input logic [119:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // One classic bus cycle; read data lands in rq.
    task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        adr <= a;
        we <= w;
        wdat <= d;
        cyc <= 1'b1;
        stb <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        chk(n < 50, 1'b1);
        rq = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    // Control word with the current mode kept.
    function automatic logic [31:0] cw(input logic [1:0] view, fn, gt,
                                       input logic up, mr, tl, tr);
        cw = {20'h0, mr, tr, tl, gt, up, fn, view, mode_v};
    endfunction
    // Random BCD value whose hundreds digit lies in lo..lo+span-1.
    function automatic logic [11:0] rbcd(input int lo, input int span);
        rbcd = {4'(lo + {$random(seed)} % span), 4'({$random(seed)} % 10),
                4'({$random(seed)} % 10)};
    endfunction
    // Hold the set position for one access, then back to centre.
    task setlim(input logic [11:0] c, input logic up, input logic [11:0] v);
        wb(OFS_CHAN, 1'b1, {20'h0, c});
        wb(OFS_VALUE, 1'b1, {20'h0, v});
        wb(OFS_CTRL, 1'b1, cw(0, POS_FIRST, 0, up, 0, 0, 0));
        wb(OFS_CTRL, 1'b1, cw(0, 0, 0, 0, 0, 0, 0));
    endtask
    // Read a limit back and compare it at the lamps and the register.
    task rdlim(input logic [11:0] c, input logic up, input logic [11:0] v);
        wb(OFS_CHAN, 1'b1, {20'h0, c});
        wb(OFS_CTRL, 1'b1, cw(0, POS_SECOND, 0, up, 0, 0, 0));
        repeat (3) @(posedge clk_i);
        chk(lv_o, v);
        wb(OFS_LIMRD, 1'b0, 0);
        chk(rq[11:0], v);
        wb(OFS_CTRL, 1'b1, cw(0, 0, 0, 0, 0, 0, 0));
        repeat (3) @(posedge clk_i);
        chk(lv_o, 12'h000);
    endtask
    // Set the gate selector for one channel, then centre.
    task gate(input logic [11:0] c, input logic [1:0] g);
        wb(OFS_CHAN, 1'b1, {20'h0, c});
        wb(OFS_CTRL, 1'b1, cw(0, 0, g, 0, 0, 0, 0));
        wb(OFS_CTRL, 1'b1, cw(0, 0, 0, 0, 0, 0, 0));
    endtask
    // Send one sample and let the lamps settle.
    task samp(input logic [6:0] c, input logic [11:0] v);
        @(posedge clk_i);
        go <= 1'b1;
        sch <= c;
        sval <= v;
        @(posedge clk_i);
        go <= 1'b0;
        repeat (6) @(posedge clk_i);
    endtask
    // Press a pushbutton pattern for one cycle.
    task press(input logic [3:0] b);
        @(posedge clk_i);
        btn <= b;
        @(posedge clk_i);
        btn <= 4'h0;
        repeat (3) @(posedge clk_i);
    endtask
    // Print the counts and the verdict, then stop.
    task print_verdict;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Cut a hang short far beyond the expected run length.
    initial begin
        #(100 * 30000);
        n_errors++;
        print_verdict;
    end
    // Main sequence.
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(OFS_CTRL, 1'b0, 0);
        chk(rq, CTRL_RST);
        wb(OFS_IMASK, 1'b0, 0);
        chk(rq, MASK_RST);
        wb(8'hFC, 1'b0, 0);
        chk(rq, 0);
        $display("registers done");
        for (i = 0; i < 4; i++) begin
            lv = rbcd(0, 5);
            setlim(12'h050, i[0], lv);
            rdlim(12'h050, i[0], lv);
        end
        setlim(12'h007, 1'b1, 12'h500);
        setlim(12'h007, 1'b0, 12'h100);
        setlim(12'h100, 1'b1, 12'h500);
        setlim(12'h100, 1'b0, 12'h100);
        rdlim(12'h007, 1'b1, 12'h500);
        rdlim(12'h007, 1'b0, 12'h100);
        gate(12'h007, POS_FIRST);
        gate(12'h100, POS_FIRST);
        for (i = 0; i < 8; i++) begin
            samp(7'd7, rbcd(1, 4));
            chk(tone_o, 1'b0);
        end
        $display("limits done");
        samp(7'd7, 12'h600);
        chk({tone_o, lamp_o, ann_o[2]}, 6'h3F);
        press(4'h4);
        chk({tone_o, lamp_o, ann_o[2]}, 6'h01);
        swa <= 1'b1;
        @(posedge clk_i);
        swa <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk(soft_o, 1'b1);
        press(4'h8);
        chk(soft_o, 1'b0);
        samp(7'd7, 12'h300);
        chk(ann_o[2], 1'b0);
        samp(7'd7, 12'h050);
        chk({tone_o, lamp_o}, 5'h1F);
        press(4'h1);
        $display("alarm done");
        mode_v = MODE_ASCENT;
        wb(OFS_CTRL, 1'b1, cw(0, 0, 0, 0, 0, 0, 0));
        samp(7'd7, 12'h300);
        samp(7'd7, 12'h600);
        chk({tone_o, lamp_o}, 5'h1E);
        press(4'h1);
        mode_v = MODE_ACK;
        wb(OFS_CTRL, 1'b1, cw(0, 0, 0, 0, 0, 0, 0));
        samp(7'd7, 12'h300);
        samp(7'd7, 12'h600);
        chk(ann_o[2], 1'b0);
        press(4'h4);
        chk(ann_o[2], 1'b0);
        press(4'h2);
        chk(ann_o[2], 1'b1);
        mode_v = MODE_REGULAR;
        $display("modes done");
        samp(7'd7, 12'h300);
        samp(7'd100, 12'h999);
        press(4'h1);
        wb(OFS_CTRL, 1'b1, cw(0, 0, 0, 0, 1, 0, 0));
        repeat (3) @(posedge clk_i);
        chk({st_o[100], st_o[7]}, 2'h3);
        mclr <= 2'h2;
        @(posedge clk_i);
        mclr <= 2'h0;
        repeat (3) @(posedge clk_i);
        chk({st_o[100], st_o[7]}, 2'h2);
        wb(OFS_CTRL, 1'b1, cw(0, 0, 0, 0, 0, 0, 0));
        gate(12'h100, POS_SECOND);
        samp(7'd100, 12'h300);
        samp(7'd100, 12'h999);
        chk(tone_o, 1'b0);
        wb(OFS_CTRL, 1'b1, cw(POS_SECOND, 0, 0, 0, 0, 0, 0));
        repeat (3) @(posedge clk_i);
        chk({st_o[100], st_o[7]}, 2'h2);
        wb(OFS_CTRL, 1'b1, cw(POS_FIRST, 0, 0, 0, 0, 0, 0));
        repeat (3) @(posedge clk_i);
        chk({st_o[100], st_o[7]}, 2'h2);
        wb(OFS_CTRL, 1'b1, cw(0, 0, 0, 0, 0, 1, 0));
        repeat (3) @(posedge clk_i);
        chk(st_o, {60'h0, {60{1'b1}}});
        wb(OFS_CTRL, 1'b1, cw(0, 0, 0, 0, 0, 0, 1));
        repeat (3) @(posedge clk_i);
        chk(st_o, {{60{1'b1}}, 60'h0});
        wb(OFS_CTRL, 1'b1, cw(0, 0, 0, 0, 0, 0, 0));
        repeat (3) @(posedge clk_i);
        chk(st_o, 120'h0);
        $display("status done");
        wb(OFS_IMASK, 1'b1, 32'h1);
        repeat (3) @(posedge clk_i);
        chk(irq_o, 1'b1);
        wb(OFS_IMASK, 1'b1, 32'h0);
        repeat (3) @(posedge clk_i);
        chk(irq_o, 1'b0);
        wb(OFS_ISTAT, 1'b1, 32'h7);
        wb(OFS_IMASK, 1'b1, 32'h7);
        repeat (3) @(posedge clk_i);
        chk(irq_o, 1'b0);
        $display("interrupt done");
        print_verdict;
    end
endmodule

// ### bench/sensor_feed.sv
`timescale 1ns/10ps
// Sensor side: hands one conditioned sample to the block when asked.
module sensor_feed (
    input  wire logic        clk_i,
    input  wire logic        go_i,
    input  wire logic [6:0]  ch_i,
    input  wire logic [11:0] val_i,
    output logic             smp_valid_o,
    output logic      [6:0]  smp_chan_o,
    output logic      [11:0] smp_value_o
);
    // Lines start idle with no sample present.
    initial begin
        smp_valid_o = 1'b0;
        smp_chan_o  = 7'h7F;
        smp_value_o = 12'hFFF;
    end
    // A sample lasts one cycle; between samples the lines toggle so no stale value is trusted.
    always @(posedge clk_i) begin
        smp_valid_o <= go_i;
        if (go_i) begin
            smp_chan_o  <= ch_i;
            smp_value_o <= val_i;
        end else begin
            smp_chan_o  <= ~smp_chan_o;
            smp_value_o <= ~smp_value_o;
        end
    end
endmodule

// ### core/alarm_annunciator.sv
// Chosen here: the register offsets and register access over Wishbone.
`timescale 1ns/10ps
module alarm_annunciator
    import annunciator_pkg::*;
#(
    parameter int NCH = 120
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [7:0]   adr_i,
    input  wire logic [31:0]  dat_i,
    input  wire logic         we_i,
    input  wire logic [3:0]   sel_i,
    input  wire logic         cyc_i,
    input  wire logic         stb_i,
    output logic      [31:0]  dat_o,
    output logic              ack_o,
    input  wire logic         smp_valid_i,
    input  wire logic [6:0]   smp_chan_i,
    input  wire logic [11:0]  smp_value_i,
    input  wire logic [3:0]   alert_button_i,
    input  wire logic [1:0]   memory_clear_i,
    input  wire logic         software_alert_i,
    output logic              tone_o,
    output logic              software_tone_o,
    output logic      [3:0]   alert_lamp_o,
    output logic      [39:0]  annunciator_o,
    output logic      [119:0] status_lamp_o,
    output logic      [11:0]  limit_volts_o,
    output logic              irq_o
);

    // Software-visible panel state.
    logic [11:0]  ctrl_r;        // Selector positions.
    logic [11:0]  chan_r;        // Channel selector, three BCD digits.
    logic [11:0]  value_r;       // Limit value, three BCD digits.
    logic [2:0]   istat_r;       // Sticky interrupt status.
    logic [2:0]   imask_r;       // Interrupt mask.
    // Per-channel state.
    logic [119:0] oor_r;         // Currently out of limits.
    logic [119:0] inh_r;         // Inhibited from triggering the alarm.
    logic [119:0] mem_r;         // Fault memory.
    // Alarm outputs.
    alarm_e       alm_r;         // Alarm sequencer.
    logic         sw_tone_r;     // Software alert tone.
    logic         tone_r;        // Alarm tone line, kept in its own flip-flop.
    logic [3:0]   alert_r;       // Urgent-alert lamps.
    logic         ack_seen_r;    // Front pushbutton pressed since last event.
    logic [39:0]  annun_r;       // Annunciator matrix.
    logic [119:0] status_r;      // Status lamps.
    logic [11:0]  volts_r;       // Limit read lamps.
    logic         irq_r;         // Interrupt line.
    logic         ack_r;         // Bus acknowledge.
    logic [31:0]  rdat_r;        // Bus read data.
    // Compare pipeline.
    logic         cmp_valid_r;   // Sample waiting for its limits.
    logic [6:0]   cmp_chan_r;    // Its channel.
    logic [11:0]  cmp_value_r;   // Its value.

    // Selector decode.
    wire [1:0] mode   = ctrl_r[CTL_MODE_LO +: 2];
    wire [1:0] view   = ctrl_r[CTL_VIEW_LO +: 2];
    wire [1:0] func   = ctrl_r[CTL_FUNC_LO +: 2];
    wire [1:0] gate   = ctrl_r[CTL_GATE_LO +: 2];
    wire       upper  = ctrl_r[CTL_UPPER];
    wire       chk_l  = ctrl_r[CTL_CHK_L];
    wire       chk_r  = ctrl_r[CTL_CHK_R];
    wire       memrd  = ctrl_r[CTL_MEMRD];

    // BCD channel selector to binary index; codes past the last channel act on none.
    wire [9:0] sel_bin = {6'h0, chan_r[11:8]} * 10'd100
                       + {6'h0, chan_r[7:4]} * 10'd10
                       + {6'h0, chan_r[3:0]};
    wire       sel_ok  = sel_bin < 10'd120;
    wire [6:0] sel_idx = sel_bin[6:0];
    wire [119:0] sel_oh = sel_ok ? (120'h1 << sel_idx) : 120'h0;

    // Limit writes happen only in the set position; centre does nothing.
    wire do_set  = (func == POS_FIRST) && sel_ok;
    wire do_read = (func == POS_SECOND) && sel_ok;

    // Limit memories, upper and lower halves written separately.
    logic [11:0] up_a, up_b, lo_a, lo_b;
    limit_store #(.DEPTH(NCH), .WIDTH(12), .AW(7)) u_upper (
        .clk_i  (clk_i),
        .we_i   (do_set && upper),
        .wa_i   (sel_idx),
        .wd_i   (value_r),
        .ra_a_i (smp_chan_i),
        .ra_b_i (sel_idx),
        .rd_a_o (up_a),
        .rd_b_o (up_b)
    );
    limit_store #(.DEPTH(NCH), .WIDTH(12), .AW(7)) u_lower (
        .clk_i  (clk_i),
        .we_i   (do_set && !upper),
        .wa_i   (sel_idx),
        .wd_i   (value_r),
        .ra_a_i (smp_chan_i),
        .ra_b_i (sel_idx),
        .rd_a_o (lo_a),
        .rd_b_o (lo_b)
    );

    // BCD words compare correctly as plain unsigned numbers.
    wire cmp_out = (cmp_value_r > up_a) || (cmp_value_r < lo_a);
    wire [119:0] scan_oh = 120'h1 << cmp_chan_r;
    wire was_oor  = |(oor_r & scan_oh);
    wire is_inh   = |(inh_r & scan_oh);
    // A fresh trip of an enabled channel is the alarm event.
    wire new_evt  = cmp_valid_r && cmp_out && !was_oor && !is_inh;

    wire btn_any  = |alert_button_i;
    wire btn_ack  = alert_button_i[0] | alert_button_i[1];
    wire clr_any  = |memory_clear_i;

    // Next per-channel state.
    wire [119:0] oor_nxt = !cmp_valid_r ? oor_r :
                           cmp_out ? (oor_r | scan_oh) : (oor_r & ~scan_oh);
    wire [119:0] inh_nxt = (gate == POS_SECOND) ? (inh_r | sel_oh) :
                           (gate == POS_FIRST) ? (inh_r & ~sel_oh) : inh_r;
    // Clearing keeps channels still out; new faults on enabled channels are recorded regardless.
    wire [119:0] mem_nxt = (clr_any ? (mem_r & oor_r) : mem_r)
                         | (oor_r & ~inh_r);

    // Alarm sequencer: a new event always wins over a press.
    alarm_e alm_nxt;
    always_comb begin
        case (alm_r)
            ALM_QUIET: alm_nxt = new_evt ? ALM_SOUND : ALM_QUIET;
            ALM_SOUND: alm_nxt = (btn_any && !new_evt) ? ALM_QUIET : ALM_SOUND;
            default:   alm_nxt = ALM_QUIET;
        endcase
    end
    wire sounding = (alm_nxt == ALM_SOUND);
    // Commander lamp (bit 0) stays dark in ascent mode.
    wire [3:0] alert_nxt = !sounding ? 4'h0 :
                           (mode == MODE_ASCENT) ? 4'hE : 4'hF;

    // Annunciator lamp per three channels of enabled trips.
    wire [119:0] live = oor_r & ~inh_r;
    logic [39:0] lamp_vec;
    for (genvar g = 0; g < LAMPS; g++) begin : g_lamp
        assign lamp_vec[g] = |live[g*CH_PER_LAMP +: CH_PER_LAMP];
    end
    wire ack_dark = (mode == MODE_ACK) && !ack_seen_r;
    wire [39:0] annun_nxt = ack_dark ? 40'h0 : lamp_vec;

    // Status lamp selection: indicator_check, then memory read, then the view selector.
    wire [119:0] test_vec = {{HALF_MATRIX{chk_r}}, {HALF_MATRIX{chk_l}}};
    wire [119:0] view_vec = (view == POS_FIRST)  ? oor_r :
                            (view == POS_SECOND) ? inh_r : 120'h0;
    wire [119:0] status_nxt = (chk_l || chk_r) ? test_vec :
                              memrd ? (oor_r | mem_r) : view_vec;

    wire [11:0] volts_nxt = !do_read ? LIMIT_RST : (upper ? up_b : lo_b);

    // Interrupt events; hardware set beats a software clear.
    wire [2:0] ievt = {software_alert_i, btn_any, new_evt};

    // Bus decode.
    wire        bus_go  = cyc_i && stb_i && !ack_r;
    wire        wr      = bus_go && we_i;
    wire [31:0] wmask   = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
    wire [11:0] wm12    = wmask[11:0];
    wire [11:0] wd12    = dat_i[11:0];
    wire wr_ctrl  = wr && (adr_i == OFS_CTRL);
    wire wr_chan  = wr && (adr_i == OFS_CHAN);
    wire wr_value = wr && (adr_i == OFS_VALUE);
    wire wr_istat = wr && (adr_i == OFS_ISTAT);
    wire wr_imask = wr && (adr_i == OFS_IMASK);
    wire [2:0] w1c = wr_istat ? (wd12[2:0] & wm12[2:0]) : 3'h0;
    wire [2:0] istat_nxt = (istat_r & ~w1c) | ievt;
    wire [3:0] state_vec = {ack_seen_r, alm_r == ALM_SOUND, sw_tone_r, 1'b0};
    wire [31:0] rd_mux =
        (adr_i == OFS_CTRL)  ? {20'h0, ctrl_r}  :
        (adr_i == OFS_CHAN)  ? {20'h0, chan_r}  :
        (adr_i == OFS_VALUE) ? {20'h0, value_r} :
        (adr_i == OFS_LIMRD) ? {20'h0, volts_r} :
        (adr_i == OFS_STATE) ? {28'h0, state_vec} :
        (adr_i == OFS_ISTAT) ? {29'h0, istat_r} :
        (adr_i == OFS_IMASK) ? {29'h0, imask_r} : 32'h0;

    // Bus slave: answer one cycle after the request, unmapped reads return zero.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r  <= 1'b0;
            rdat_r <= 32'h0;
        end else begin
            ack_r  <= bus_go;
            rdat_r <= bus_go ? rd_mux : 32'h0;
        end
    end

    // Software registers with byte-lane masking.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r  <= CTRL_RST;
            chan_r  <= 12'h000;
            value_r <= 12'h000;
            imask_r <= MASK_RST;
            istat_r <= 3'h0;
        end else begin
            ctrl_r  <= wr_ctrl  ? ((ctrl_r & ~wm12) | (wd12 & wm12)) : ctrl_r;
            chan_r  <= wr_chan  ? ((chan_r & ~wm12) | (wd12 & wm12)) : chan_r;
            value_r <= wr_value ? ((value_r & ~wm12) | (wd12 & wm12)) : value_r;
            imask_r <= wr_imask ? (wd12[2:0] & wm12[2:0]) | (imask_r & ~wm12[2:0])
                                : imask_r;
            istat_r <= istat_nxt;
        end
    end

    // Sample pipeline: limits arrive one cycle after the sample.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmp_valid_r <= 1'b0;
            cmp_chan_r  <= 7'h00;
            cmp_value_r <= 12'h000;
        end else begin
            cmp_valid_r <= smp_valid_i && (smp_chan_i < 7'd120);
            cmp_chan_r  <= smp_chan_i;
            cmp_value_r <= smp_value_i;
        end
    end

    // Per-channel state.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            oor_r <= 120'h0;
            inh_r <= 120'h0;
            mem_r <= 120'h0;
        end else begin
            oor_r <= oor_nxt;
            inh_r <= inh_nxt;
            mem_r <= mem_nxt;
        end
    end

    // Alarm and lamp outputs.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            alm_r      <= ALM_QUIET;
            sw_tone_r  <= 1'b0;
            tone_r     <= 1'b0;
            alert_r    <= 4'h0;
            ack_seen_r <= 1'b0;
            annun_r    <= 40'h0;
            status_r   <= 120'h0;
            volts_r    <= LIMIT_RST;
            irq_r      <= 1'b0;
        end else begin
            alm_r      <= alm_nxt;
            tone_r     <= sounding;
            // A fresh software alert wins over a press in the same cycle.
            sw_tone_r  <= software_alert_i || (sw_tone_r && !btn_any);
            alert_r    <= alert_nxt;
            // A press of button 0 or 1 wins over the event that re-darkens the matrix.
            ack_seen_r <= btn_ack || (ack_seen_r && !new_evt);
            annun_r    <= annun_nxt;
            status_r   <= status_nxt;
            volts_r    <= volts_nxt;
            irq_r      <= |(istat_nxt & imask_r);
        end
    end

    assign dat_o           = rdat_r;
    assign ack_o           = ack_r;
    assign tone_o          = tone_r;
    assign software_tone_o = sw_tone_r;
    assign alert_lamp_o    = alert_r;
    assign annunciator_o   = annun_r;
    assign status_lamp_o   = status_r;
    assign limit_volts_o   = volts_r;
    assign irq_o           = irq_r;

    // Checks on the block's own behaviour.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_event_sounds:
    assert property (new_evt |=> tone_o && (alert_lamp_o[3:1] == 3'h7))
        else $error("event did not sound the alarm");
    chk_press_silences:
    assert property (btn_any && !new_evt |=> !tone_o && alert_lamp_o == 4'h0)
        else $error("press did not silence the alarm");
    chk_soft_reset:
    assert property (btn_any && !software_alert_i |=> !software_tone_o)
        else $error("software tone survived a press");
    chk_ascent_cdr:
    assert property (alert_lamp_o[0] |-> $past(mode) != MODE_ASCENT)
        else $error("commander lamp lit in ascent mode");
    chk_ack_dark:
    assert property (ack_dark && !btn_ack |=> annunciator_o == 40'h0)
        else $error("matrix lit before acknowledge");
    chk_tripped_view:
    assert property (view == POS_FIRST && !chk_l && !chk_r && !memrd
                     |=> status_lamp_o == $past(oor_r))
        else $error("tripped view wrong");
    chk_inhibited_view:
    assert property (view == POS_SECOND && !chk_l && !chk_r && !memrd
                     |=> status_lamp_o == $past(inh_r))
        else $error("inhibited view wrong");
    chk_memory_read:
    assert property (memrd && !chk_l && !chk_r
                     |=> status_lamp_o == ($past(oor_r) | $past(mem_r)))
        else $error("memory read view wrong");
    chk_clear_keeps:
    assert property (clr_any |=> (mem_r & $past(oor_r) & $past(mem_r))
                                 == ($past(oor_r) & $past(mem_r)))
        else $error("clear dropped an out-of-limit channel");
    chk_clear_drops:
    assert property (clr_any |=> (mem_r & ~$past(oor_r)) == 120'h0)
        else $error("clear kept a channel within limits");
    chk_test_left:
    assert property (chk_l |=> &status_lamp_o[59:0])
        else $error("left indicator_check incomplete");
    chk_rearm_event:
    assert property (!tone_o ##1 new_evt |=> tone_o && alert_lamp_o != 4'h0)
        else $error("alarm not re-armed");
    chk_bus_answer:
    assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
        else $error("bus answer not one cycle");

    cov_alarm_ack:  cover property (new_evt ##[1:20] btn_any);
    cov_clear_mem:  cover property (clr_any && |(mem_r & ~oor_r));
    cov_limit_set:  cover property (do_set ##1 do_read);
    cov_ack_mode:   cover property (ack_dark ##1 btn_ack);

endmodule

// ### core/annunciator_pkg.sv
package annunciator_pkg;

    // Channel counts and lamp geometry.
    localparam int CHANNELS     = 120;
    localparam int LAMPS        = 40;
    localparam int CH_PER_LAMP  = 3;
    localparam int HALF_MATRIX  = 60;

    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_CHAN   = 8'h04;
    localparam logic [7:0] OFS_VALUE  = 8'h08;
    localparam logic [7:0] OFS_LIMRD  = 8'h0C;
    localparam logic [7:0] OFS_STATE  = 8'h10;
    localparam logic [7:0] OFS_ISTAT  = 8'h14;
    localparam logic [7:0] OFS_IMASK  = 8'h18;

    // Control register field positions.
    localparam int CTL_MODE_LO  = 0;
    localparam int CTL_VIEW_LO  = 2;
    localparam int CTL_FUNC_LO  = 4;
    localparam int CTL_UPPER    = 6;
    localparam int CTL_GATE_LO  = 7;
    localparam int CTL_CHK_L    = 9;
    localparam int CTL_CHK_R    = 10;
    localparam int CTL_MEMRD    = 11;

    // Selector position codes.
    localparam logic [1:0] MODE_REGULAR = 2'h0;
    localparam logic [1:0] MODE_ASCENT  = 2'h1;
    localparam logic [1:0] MODE_ACK     = 2'h2;
    localparam logic [1:0] POS_CENTRE   = 2'h0;
    localparam logic [1:0] POS_FIRST    = 2'h1;
    localparam logic [1:0] POS_SECOND   = 2'h2;

    // Interrupt status bit positions.
    localparam int IRQ_ALARM = 0;
    localparam int IRQ_PRESS = 1;
    localparam int IRQ_SOFT  = 2;

    // Reset values.
    localparam logic [11:0] CTRL_RST  = 12'h000;
    localparam logic [11:0] LIMIT_RST = 12'h000;
    localparam logic [2:0]  MASK_RST  = 3'h0;

    // Alarm sequencer states.
    typedef enum logic [1:0] {
        ALM_QUIET = 2'b01,
        ALM_SOUND = 2'b10
    } alarm_e;

endpackage

// ### core/limit_store.sv
`timescale 1ns/10ps
// One limit per channel, with one write port and two registered read ports.
module limit_store #(
    parameter int DEPTH = 120,
    parameter int WIDTH = 12,
    parameter int AW    = 7
) (
    input  wire logic             clk_i,
    input  wire logic             we_i,
    input  wire logic [AW-1:0]    wa_i,
    input  wire logic [WIDTH-1:0] wd_i,
    input  wire logic [AW-1:0]    ra_a_i,
    input  wire logic [AW-1:0]    ra_b_i,
    output logic      [WIDTH-1:0] rd_a_o,
    output logic      [WIDTH-1:0] rd_b_o
);

    logic [WIDTH-1:0] mem [DEPTH];  // Limit words.

    // Both read ports register the word held before this cycle's write.
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[wa_i] <= wd_i;
        end
        rd_a_o <= mem[ra_a_i];
        rd_b_o <= mem[ra_b_i];
    end

endmodule
